// [verilog/ltx_tx_select.sv]
`include "ltx_params.svh"

// Notes on behaviour
// - Standard pin: low E3, high DS3, float STS-1.
// - Extended enable high: source from selects and standard.
// - Extended enable low: always send framer data.
// - Select 00 framer data; 01 unframed ones.
// - Select 10: alternating, or DS3 alarm signal.
// - Select 11: 2^23-1 on E3, else 2^15-1.
// - Suppression low: coder and NRZ; high: bipolar.
// - NRZ mode: data on positive input, negative ignored.
// - Clock invert low: rising edge; otherwise falling.
// - Tri-state: low off, high on, float adds attenuator.
// - Monitor float: attenuator receive side, preamp off.
// - Internal oscillator strap forces upper select low.
// - Undefined float states only flag factory test.
module ltx_tx_select
	import ltx_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire ltx_tri_t line_standard_sel_i,
	input wire ltx_tri_t tx_source_sel_hi_i,
	input wire ltx_tri_t tx_source_sel_lo_i,
	input wire ltx_tri_t tx_driver_tristate_n_i,
	input wire ltx_tri_t rx_monitor_sel_i,
	input wire ltx_tri_t clock_edge_invert_sel_i,
	input wire ltx_tri_t tx_negative_in_i,
	input wire logic extended_features_en_i,
	input wire logic zero_suppress_coding_en_n_i,
	input wire logic master_clock_low_i,
	input wire logic transmit_clock_in_i,
	input wire logic tx_positive_or_nrz_in_i,
	output logic tx_pos_o,
	output logic tx_neg_o,
	output logic bit_strobe_o,
	output ltx_ctrl_t ctrl_o
);

	// Whole state of the block.
	typedef struct packed {
		ltx_pins_t meta;
		ltx_pins_t pins;
		logic transmit_clock_in_prev;
		logic pos;
		logic neg;
		logic strobe;
		ltx_ctrl_t ctrl;
	} ltx_state_t;

	ltx_state_t st_r;
	ltx_state_t st_nxt;
	ltx_pins_t pin_now;
	ltx_ctrl_t dec;
	logic take;
	logic gen_bit;
	logic src_bit;

	// Raw pins gathered into one bundle for the synchroniser.
	assign pin_now = '{line_standard_sel: line_standard_sel_i, tds_hi: tx_source_sel_hi_i,
		tds_lo: tx_source_sel_lo_i, tts_n: tx_driver_tristate_n_i, rx_monitor_sel: rx_monitor_sel_i,
		clock_edge_invert_sel: clock_edge_invert_sel_i, tx_negative_in: tx_negative_in_i, efe: extended_features_en_i,
		zero_suppress_coding_en_n_n: zero_suppress_coding_en_n_i, mclk_low: master_clock_low_i,
		transmit_clock_in: transmit_clock_in_i, tpos: tx_positive_or_nrz_in_i};

	// Pick the transmit clock edge that samples the framer data.
	always_comb begin
		if (st_r.pins.clock_edge_invert_sel == LTX_TRI_LOW) begin
			take = st_r.pins.transmit_clock_in & ~st_r.transmit_clock_in_prev;
		end else begin
			take = ~st_r.pins.transmit_clock_in & st_r.transmit_clock_in_prev;
		end
	end

	// Decode of the control pins from their synchronised copies.
	always_comb begin
		dec = '0;
		// Line standard.
		case (st_r.pins.line_standard_sel)
			LTX_TRI_LOW: dec.std = LTX_STD_E3;
			LTX_TRI_HIGH: dec.std = LTX_STD_DS3;
			default: dec.std = LTX_STD_STS1;
		endcase
		// Source selection; a float on a select or the negative pin only flags test.
		dec.src = LTX_SRC_NORMAL;
		if (st_r.pins.efe) begin
			if (st_r.pins.tds_lo == LTX_TRI_FLOAT
				|| (st_r.pins.tds_hi == LTX_TRI_FLOAT && !st_r.pins.mclk_low)) begin
				dec.factory_test = 1'b1;
			end else if (st_r.pins.tds_hi == LTX_TRI_HIGH && !st_r.pins.mclk_low) begin
				if (st_r.pins.tds_lo == LTX_TRI_LOW) begin
					dec.src = (dec.std == LTX_STD_DS3) ? LTX_SRC_AIS : LTX_SRC_ALT;
				end else begin
					dec.src = (dec.std == LTX_STD_E3) ? LTX_SRC_PRBS23 : LTX_SRC_PRBS15;
				end
			end else if (st_r.pins.tds_lo == LTX_TRI_HIGH) begin
				dec.src = LTX_SRC_ONES;
			end
		end
		if (st_r.pins.tx_negative_in == LTX_TRI_FLOAT || st_r.pins.tts_n == LTX_TRI_RSVD) begin
			dec.factory_test = 1'b1;
		end
		// Coding mode.
		dec.nrz_mode = ~st_r.pins.zero_suppress_coding_en_n_n;
		// Driver, attenuator and preamp.
		dec.driver_en = st_r.pins.tts_n != LTX_TRI_LOW;
		dec.preamp_en = st_r.pins.rx_monitor_sel == LTX_TRI_HIGH;
		if (st_r.pins.rx_monitor_sel == LTX_TRI_FLOAT) begin
			dec.ja_rx = 1'b1;
		end else begin
			dec.ja_tx = st_r.pins.tts_n == LTX_TRI_FLOAT;
		end
	end

	// Pattern generator advances once per sampled bit.
	ltx_pattern_gen u_gen (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.step_i(take),
		.mode_i(dec.src),
		.bit_o(gen_bit)
	);

	// Bit that feeds the encoder: framer data or an internal pattern.
	always_comb begin
		case (dec.src)
			LTX_SRC_NORMAL: src_bit = st_r.pins.tpos;
			LTX_SRC_ONES: src_bit = 1'b1;
			default: src_bit = gen_bit;
		endcase
	end

	// Next state: synchroniser, edge history, sampled bits and decoded controls.
	always_comb begin
		st_nxt = st_r;
		st_nxt.meta = pin_now;
		st_nxt.pins = st_r.meta;
		st_nxt.transmit_clock_in_prev = st_r.pins.transmit_clock_in;
		st_nxt.ctrl = dec;
		st_nxt.strobe = take;
		if (take) begin
			st_nxt.pos = src_bit;
			// Negative input only counts for framer data on the bipolar interface.
			st_nxt.neg = dec.src == LTX_SRC_NORMAL && !dec.nrz_mode
				&& st_r.pins.tx_negative_in == LTX_TRI_HIGH;
		end
	end

	// State register.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tx_pos_o = st_r.pos;
	assign tx_neg_o = st_r.neg;
	assign bit_strobe_o = st_r.strobe;
	assign ctrl_o = st_r.ctrl;

	// Sampling edge of the transmit clock as seen by the synchroniser.
	sequence s_rise;
		!st_r.transmit_clock_in_prev ##0 st_r.pins.transmit_clock_in;
	endsequence

	sequence s_fall;
		st_r.transmit_clock_in_prev ##0 !st_r.pins.transmit_clock_in;
	endsequence

	a_std_decode: assert property (@(posedge clk_i) disable iff (reset_i)
		st_r.pins.line_standard_sel == LTX_TRI_FLOAT |=> ctrl_o.std == LTX_STD_STS1)
		else $error("Float standard pin did not select STS-1");

	a_efe_off: assert property (@(posedge clk_i) disable iff (reset_i)
		!st_r.pins.efe |=> ctrl_o.src == LTX_SRC_NORMAL)
		else $error("Source not normal with extended features off");

	a_prbs_pick: assert property (@(posedge clk_i) disable iff (reset_i)
		st_r.pins.efe && !st_r.pins.mclk_low && st_r.pins.tds_hi == LTX_TRI_HIGH
		&& st_r.pins.tds_lo == LTX_TRI_HIGH && st_r.pins.line_standard_sel == LTX_TRI_LOW
		|=> ctrl_o.src == LTX_SRC_PRBS23)
		else $error("E3 PRBS length wrong");

	a_osc_force: assert property (@(posedge clk_i) disable iff (reset_i)
		st_r.pins.mclk_low |=> ctrl_o.src inside {LTX_SRC_NORMAL, LTX_SRC_ONES})
		else $error("Upper select not forced low on internal oscillator");

	a_rise_take: assert property (@(posedge clk_i) disable iff (reset_i)
		st_r.pins.clock_edge_invert_sel == LTX_TRI_LOW ##0 s_rise |=> bit_strobe_o)
		else $error("Rising edge not sampled");

	a_fall_take: assert property (@(posedge clk_i) disable iff (reset_i)
		st_r.pins.clock_edge_invert_sel != LTX_TRI_LOW ##0 s_fall ##0 st_r.pins.efe == 1'b0
		|=> bit_strobe_o && tx_pos_o == $past(st_r.pins.tpos))
		else $error("Falling edge data not captured");

	a_ones_out: assert property (@(posedge clk_i) disable iff (reset_i)
		take && dec.src == LTX_SRC_ONES |=> tx_pos_o && !tx_neg_o)
		else $error("All ones source sent a zero");

	a_nrz_neg: assert property (@(posedge clk_i) disable iff (reset_i)
		ctrl_o.nrz_mode |-> !tx_neg_o || $past(!ctrl_o.nrz_mode, 1) || !bit_strobe_o)
		else $error("Negative input used in NRZ mode");

	a_driver_ja: assert property (@(posedge clk_i) disable iff (reset_i)
		st_r.pins.tts_n == LTX_TRI_LOW ##1 st_r.pins.tts_n == LTX_TRI_LOW
		|-> !ctrl_o.driver_en && !ctrl_o.ja_tx)
		else $error("Driver active while tri-stated");

	a_monitor: assert property (@(posedge clk_i) disable iff (reset_i)
		st_r.pins.rx_monitor_sel == LTX_TRI_FLOAT |=> ctrl_o.ja_rx && !ctrl_o.ja_tx && !ctrl_o.preamp_en)
		else $error("Monitor float decode wrong");

endmodule : ltx_tx_select

// [verilog/ltx_params.svh]
`ifndef LTX_PARAMS_SVH
`define LTX_PARAMS_SVH

// Two-flop pin synchroniser depth, stated for reference only; the bench does not use it.
`define LTX_SYNC_STAGES 2

// PRBS generator taps (bit positions in the shift register) and seed.
`define LTX_PRBS15_MSB 14
`define LTX_PRBS15_TAP 13
`define LTX_PRBS23_MSB 22
`define LTX_PRBS23_TAP 17
`define LTX_PRBS_SEED 23'h7fffff
`define LTX_PRBS_ZERO 23'h000000

// DS3 alarm signal frame geometry: 7 subframes, 8 blocks, 85 bits per block.
`define LTX_AIS_SUB_LAST 3'h6
`define LTX_AIS_BLK_LAST 3'h7
`define LTX_AIS_POS_LAST 7'h54
`define LTX_AIS_POS_OH 7'h00

// Overhead bit values: F bits per block, M bits per subframe.
`define LTX_AIS_F_BITS 8'h82
`define LTX_AIS_M_BITS 7'h20
`define LTX_AIS_X_SUBS 7'h03

`endif

// [verilog/ltx_pkg.sv]
package ltx_pkg;

	// Resolved state of a three-level control pin.
	typedef enum logic [1:0] {
		LTX_TRI_LOW = 2'b00,
		LTX_TRI_HIGH = 2'b01,
		LTX_TRI_FLOAT = 2'b10,
		LTX_TRI_RSVD = 2'b11
	} ltx_tri_t;

	// Selected line standard.
	typedef enum logic [1:0] {
		LTX_STD_E3 = 2'b00,
		LTX_STD_DS3 = 2'b01,
		LTX_STD_STS1 = 2'b10
	} ltx_std_t;

	// Transmit data source.
	typedef enum logic [2:0] {
		LTX_SRC_NORMAL = 3'b000,
		LTX_SRC_ONES = 3'b001,
		LTX_SRC_ALT = 3'b010,
		LTX_SRC_AIS = 3'b011,
		LTX_SRC_PRBS15 = 3'b100,
		LTX_SRC_PRBS23 = 3'b101
	} ltx_src_t;

	// All pins seen by the block, captured together by the synchroniser.
	typedef struct packed {
		ltx_tri_t line_standard_sel;
		ltx_tri_t tds_hi;
		ltx_tri_t tds_lo;
		ltx_tri_t tts_n;
		ltx_tri_t rx_monitor_sel;
		ltx_tri_t clock_edge_invert_sel;
		ltx_tri_t tx_negative_in;
		logic efe;
		logic zero_suppress_coding_en_n_n;
		logic mclk_low;
		logic transmit_clock_in;
		logic tpos;
	} ltx_pins_t;

	// Decoded control outputs.
	typedef struct packed {
		ltx_std_t std;
		ltx_src_t src;
		logic nrz_mode;
		logic driver_en;
		logic ja_tx;
		logic ja_rx;
		logic preamp_en;
		logic factory_test;
	} ltx_ctrl_t;

endpackage : ltx_pkg

// [verilog/ltx_pattern_gen.sv]
`include "ltx_params.svh"

// Internal pattern source: alternating, DS3 alarm signal and two PRBS lengths.
module ltx_pattern_gen
	import ltx_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic step_i,
	input wire ltx_src_t mode_i,
	output logic bit_o
);

	// Whole state of the generator.
	typedef struct packed {
		logic [22:0] lfsr;
		logic alt;
		logic [2:0] sub;
		logic [2:0] blk;
		logic [6:0] pos;
	} ltx_gen_state_t;

	ltx_gen_state_t st_r;
	ltx_gen_state_t st_nxt;
	logic ais_bit;
	logic [7:0] f_bits; // F overhead bit per block, indexed by block number.
	logic [6:0] m_bits; // X and M overhead bits per subframe, indexed by subframe.

	// Overhead bit tables held as plain vectors so a block or subframe index picks one bit.
	assign f_bits = `LTX_AIS_F_BITS;
	assign m_bits = `LTX_AIS_X_SUBS | `LTX_AIS_M_BITS;

	// Alarm-signal bit for the current frame position: payload 1010, C bits zero.
	always_comb begin
		if (st_r.pos != `LTX_AIS_POS_OH) begin
			ais_bit = st_r.pos[0];
		end else if (st_r.blk[0]) begin
			ais_bit = f_bits[st_r.blk];
		end else if (st_r.blk == 3'h0) begin
			ais_bit = m_bits[st_r.sub];
		end else begin
			ais_bit = 1'b0;
		end
	end

	// Output bit chosen from the mode; PRBS output is inverted as usual for these lengths.
	always_comb begin
		case (mode_i)
			LTX_SRC_ALT: bit_o = st_r.alt;
			LTX_SRC_AIS: bit_o = ais_bit;
			LTX_SRC_PRBS15: bit_o = ~st_r.lfsr[`LTX_PRBS15_MSB];
			LTX_SRC_PRBS23: bit_o = ~st_r.lfsr[`LTX_PRBS23_MSB];
			default: bit_o = 1'b1;
		endcase
	end

	// Advance every generator by one bit per step; the shared PRBS register steps as 23-bit only in PRBS23 mode, else as 15-bit.
	always_comb begin
		st_nxt = st_r;
		if (step_i) begin
			st_nxt.alt = ~st_r.alt;
			if (mode_i == LTX_SRC_PRBS23) begin
				st_nxt.lfsr = {st_r.lfsr[21:0],
					st_r.lfsr[`LTX_PRBS23_MSB] ^ st_r.lfsr[`LTX_PRBS23_TAP]};
			end else begin
				st_nxt.lfsr = {8'h00, st_r.lfsr[13:0],
					st_r.lfsr[`LTX_PRBS15_MSB] ^ st_r.lfsr[`LTX_PRBS15_TAP]};
			end
			if (st_nxt.lfsr == `LTX_PRBS_ZERO) begin
				st_nxt.lfsr = `LTX_PRBS_SEED;
			end
			if (st_r.pos == `LTX_AIS_POS_LAST) begin
				st_nxt.pos = `LTX_AIS_POS_OH;
				st_nxt.blk = st_r.blk + 3'h1;
				if (st_r.blk == `LTX_AIS_BLK_LAST) begin
					st_nxt.sub = (st_r.sub == `LTX_AIS_SUB_LAST) ? 3'h0 : st_r.sub + 3'h1;
				end
			end else begin
				st_nxt.pos = st_r.pos + 7'h01;
			end
		end
	end

	// State register.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_r <= '{lfsr: `LTX_PRBS_SEED, alt: 1'b1, sub: 3'h0, blk: 3'h0, pos: 7'h00};
		end else begin
			st_r <= st_nxt;
		end
	end

	// The shift register never locks up at zero.
	a_prbs_alive: assert property (@(posedge clk_i) disable iff (reset_i)
		st_r.lfsr != `LTX_PRBS_ZERO)
		else $error("PRBS register reached zero");

	// Alternating pattern flips on every step.
	a_alt_toggle: assert property (@(posedge clk_i) disable iff (reset_i)
		step_i |=> st_r.alt != $past(st_r.alt))
		else $error("Alternating pattern did not toggle");

endmodule : ltx_pattern_gen

// [dv/ltx_framer_model.sv]
// Framer on the far side: a transmit clock that stands still between frames, plus bit data.
module ltx_framer_model
	import ltx_pkg::*;
(
	input wire logic fall_sample_i,
	output logic transmit_clock_in_o,
	output logic tpos_o,
	output ltx_tri_t tx_negative_in_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// Lines start quiet before the first frame.
	initial begin
		transmit_clock_in_o = 1'b0;
		tpos_o = 1'b0;
		tx_negative_in_o = LTX_TRI_LOW;
	end

	// Sends sixteen bits, first bit lowest, at a 125 ns period.
	// Data moves on the edge that the block does not sample, so it is stable around the other.
	task automatic send(input logic [15:0] pos, input logic [15:0] neg);
		transmit_clock_in_o = fall_sample_i;
		#62.5;
		for (int i = 0; i < 16; i++) begin
			tpos_o = pos[i];
			tx_negative_in_o = neg[i] ? LTX_TRI_HIGH : LTX_TRI_LOW;
			#62.5;
			transmit_clock_in_o = ~transmit_clock_in_o;
			#62.5;
			transmit_clock_in_o = ~transmit_clock_in_o;
		end
		// Released data flips so that a stale bit can never pass for a good one.
		tpos_o = ~tpos_o;
		tx_negative_in_o = (tx_negative_in_o == LTX_TRI_HIGH) ? LTX_TRI_LOW : LTX_TRI_HIGH;
	endtask : send
endmodule : ltx_framer_model

// [dv/ltx_tx_select_tb.sv]
// Self-checking bench for the transmit select and control decode block.
module ltx_tx_select_tb
	import ltx_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_i = 1'b0; // System clock.
	logic reset_i = 1'b1; // Held high for the first cycles.
	ltx_tri_t line_standard_sel = LTX_TRI_LOW, hi = LTX_TRI_LOW, lo = LTX_TRI_LOW; // Select pins.
	ltx_tri_t tx_driver_tristate_n = LTX_TRI_HIGH, rx_monitor_sel = LTX_TRI_LOW, clock_edge_invert_sel = LTX_TRI_LOW; // Mode pins.
	logic efe = 1'b0, zero_suppress_coding_en_n_n = 1'b1, mclk_low = 1'b0; // Two-level straps.
	logic transmit_clock_in, tpos, tx_pos, tx_neg, strobe; // Link and bit outputs.
	ltx_tri_t tx_negative_in; // Negative data from the framer.
	ltx_ctrl_t ctrl; // Decoded controls.
	logic [15:0] cap_pos = '0, cap_neg = '0; // Bits seen at strobes, first bit lowest.
	int n_bits = 0, n_mismatch = 0, compares = 0, cycles = 0;

	// Clock of 10 ns period.
	always #5 clk_i = ~clk_i;

	ltx_tx_select u_ltx_tx_select (.clk_i(clk_i), .reset_i(reset_i),
		.line_standard_sel_i(line_standard_sel), .tx_source_sel_hi_i(hi), .tx_source_sel_lo_i(lo),
		.tx_driver_tristate_n_i(tx_driver_tristate_n), .rx_monitor_sel_i(rx_monitor_sel), .clock_edge_invert_sel_i(clock_edge_invert_sel),
		.tx_negative_in_i(tx_negative_in), .extended_features_en_i(efe),
		.zero_suppress_coding_en_n_i(zero_suppress_coding_en_n_n), .master_clock_low_i(mclk_low),
		.transmit_clock_in_i(transmit_clock_in), .tx_positive_or_nrz_in_i(tpos), .tx_pos_o(tx_pos),
		.tx_neg_o(tx_neg), .bit_strobe_o(strobe), .ctrl_o(ctrl));

	ltx_framer_model u_ltx_framer_model (.fall_sample_i(clock_edge_invert_sel != LTX_TRI_LOW),
		.transmit_clock_in_o(transmit_clock_in), .tpos_o(tpos), .tx_negative_in_o(tx_negative_in));

	// Shifts in the bits offered at each strobe, read mid-cycle where the outputs are settled.
	always @(negedge clk_i) begin
		if (strobe === 1'b1) begin
			cap_pos <= {tx_pos, cap_pos[15:1]};
			cap_neg <= {tx_neg, cap_neg[15:1]};
			n_bits <= n_bits + 1;
		end
	end

	// Cuts a hang short well beyond the expected run length.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end

	// Compares one value and reports a difference at once.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	// Lets pin changes pass the synchroniser and decode.
	task automatic settle();
		repeat (5) @(negedge clk_i);
	endtask : settle

	// Runs one frame through the framer and checks that every bit gave one strobe.
	task automatic frame(input logic [15:0] pos, input logic [15:0] neg);
		@(negedge clk_i);
		n_bits = 0;
		u_ltx_framer_model.send(pos, neg);
		settle();
		check(16'(n_bits), 16'd16);
	endtask : frame

	// Walks every monitor and tri-state combination.
	task automatic t_controls();
		ltx_tri_t r;
		ltx_tri_t t;
		for (int i = 0; i < 9; i++) begin
			r = ltx_tri_t'(i / 3);
			t = ltx_tri_t'(i % 3);
			@(negedge clk_i);
			rx_monitor_sel = r;
			tx_driver_tristate_n = t;
			settle();
			check(16'(ctrl.driver_en), 16'(t != LTX_TRI_LOW));
			check(16'(ctrl.ja_tx), 16'(r != LTX_TRI_FLOAT && t == LTX_TRI_FLOAT));
			check(16'(ctrl.ja_rx), 16'(r == LTX_TRI_FLOAT));
			check(16'(ctrl.preamp_en), 16'(r == LTX_TRI_HIGH));
		end
		$display("controls test done");
	endtask : t_controls

	// Sets the select straps and checks source, test flag and standard.
	task automatic src_case(input ltx_tri_t h, input ltx_tri_t l, input ltx_tri_t s,
		input logic e, input logic m, input ltx_src_t exp, input logic ft);
		@(negedge clk_i);
		hi = h;
		lo = l;
		line_standard_sel = s;
		efe = e;
		mclk_low = m;
		settle();
		check(16'(ctrl.src), 16'(exp));
		check(16'(ctrl.factory_test), 16'(ft));
		check(16'(ctrl.std), 16'(s == LTX_TRI_LOW ? LTX_STD_E3 :
			s == LTX_TRI_HIGH ? LTX_STD_DS3 : LTX_STD_STS1));
	endtask : src_case

	// Covers every row of the source table and the override cases.
	task automatic t_source();
		src_case(LTX_TRI_LOW, LTX_TRI_LOW, LTX_TRI_HIGH, 1, 0, LTX_SRC_NORMAL, 0);
		src_case(LTX_TRI_LOW, LTX_TRI_HIGH, LTX_TRI_LOW, 1, 0, LTX_SRC_ONES, 0);
		src_case(LTX_TRI_HIGH, LTX_TRI_LOW, LTX_TRI_LOW, 1, 0, LTX_SRC_ALT, 0);
		src_case(LTX_TRI_HIGH, LTX_TRI_LOW, LTX_TRI_FLOAT, 1, 0, LTX_SRC_ALT, 0);
		src_case(LTX_TRI_HIGH, LTX_TRI_LOW, LTX_TRI_HIGH, 1, 0, LTX_SRC_AIS, 0);
		src_case(LTX_TRI_HIGH, LTX_TRI_HIGH, LTX_TRI_LOW, 1, 0, LTX_SRC_PRBS23, 0);
		src_case(LTX_TRI_HIGH, LTX_TRI_HIGH, LTX_TRI_HIGH, 1, 0, LTX_SRC_PRBS15, 0);
		src_case(LTX_TRI_HIGH, LTX_TRI_HIGH, LTX_TRI_FLOAT, 1, 0, LTX_SRC_PRBS15, 0);
		src_case(LTX_TRI_HIGH, LTX_TRI_HIGH, LTX_TRI_LOW, 0, 0, LTX_SRC_NORMAL, 0);
		src_case(LTX_TRI_HIGH, LTX_TRI_HIGH, LTX_TRI_LOW, 1, 1, LTX_SRC_ONES, 0);
		src_case(LTX_TRI_LOW, LTX_TRI_FLOAT, LTX_TRI_LOW, 1, 0, LTX_SRC_NORMAL, 1);
		$display("source test done");
	endtask : t_source

	// Framer data in bipolar and NRZ modes, on each sampling edge choice.
	task automatic t_data();
		for (int k = 0; k < 4; k++) begin
			@(negedge clk_i);
			clock_edge_invert_sel = k[0] ? (k[1] ? LTX_TRI_FLOAT : LTX_TRI_HIGH) : LTX_TRI_LOW;
			zero_suppress_coding_en_n_n = ~k[1];
			efe = 1'b0;
			settle();
			check(16'(ctrl.nrz_mode), 16'(k[1]));
			frame(16'ha5c3, 16'h1a28);
			check(cap_pos, 16'ha5c3);
			check(cap_neg, k[1] ? 16'h0000 : 16'h1a28);
		end
		$display("data test done");
	endtask : t_data

	// Internal ones and alternating patterns replace framer bits one per clock.
	task automatic t_patterns();
		src_case(LTX_TRI_LOW, LTX_TRI_HIGH, LTX_TRI_LOW, 1, 0, LTX_SRC_ONES, 0);
		frame(16'h0000, 16'hffff);
		check(cap_pos, 16'hffff);
		check(cap_neg, 16'h0000);
		src_case(LTX_TRI_HIGH, LTX_TRI_LOW, LTX_TRI_LOW, 1, 0, LTX_SRC_ALT, 0);
		frame(16'hffff, 16'h0000);
		check(16'(cap_pos == 16'haaaa || cap_pos == 16'h5555), 16'h0001);
		$display("pattern test done");
	endtask : t_patterns

	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	// Main sequence: reset, then each test in turn.
	initial begin
		repeat (8) @(negedge clk_i);
		check(16'(ctrl), 16'h0000);
		reset_i = 1'b0;
		settle();
		t_controls();
		t_source();
		t_data();
		t_patterns();
		finish_test();
	end
endmodule : ltx_tx_select_tb
